// file: pkg/pag_pkg.sv
// Purpose: Shared constants for the PWM action generator
// Assumes: Word-addressed Avalon-MM slave, 32-bit data
// Notes:   Event vector and action fields share one index scheme
package pag_pkg;
	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int CNT_W  = 16;
	localparam int CFG_W  = 24;
	localparam int EV_N   = 12;
	localparam int ADDR_W = 4;
	localparam int SHD_N  = 4;
	// ------------------------------------------------------------
	// Register indices (word addresses)
	// ------------------------------------------------------------
	localparam logic [3:0] REG_CMP_A   = 4'h0;
	localparam logic [3:0] REG_CMP_B   = 4'h1;
	localparam logic [3:0] REG_ACT_A   = 4'h2;
	localparam logic [3:0] REG_ACT_B   = 4'h3;
	localparam logic [3:0] REG_UPDATE  = 4'h4;
	localparam logic [3:0] REG_FORCE   = 4'h5;
	localparam logic [3:0] REG_STATUS  = 4'h6;
	localparam logic [3:0] REG_ACT_CMP = 4'h7;
	localparam logic [3:0] REG_LAST    = 4'h7;
	// ------------------------------------------------------------
	// Event vector bit positions; action field is cfg[2*pos +: 2]
	// ------------------------------------------------------------
	localparam int EV_UZ  = 0;
	localparam int EV_UP  = 1;
	localparam int EV_UA  = 2;
	localparam int EV_UB  = 3;
	localparam int EV_UT0 = 4;
	localparam int EV_UT1 = 5;
	localparam int EV_DZ  = 6;
	localparam int EV_DP  = 7;
	localparam int EV_DA  = 8;
	localparam int EV_DB  = 9;
	localparam int EV_DT0 = 10;
	localparam int EV_DT1 = 11;
	// ------------------------------------------------------------
	// Action codes
	// ------------------------------------------------------------
	localparam logic [1:0] ACT_NONE = 2'h0;
	localparam logic [1:0] ACT_LOW  = 2'h1;
	localparam logic [1:0] ACT_HIGH = 2'h2;
	localparam logic [1:0] ACT_TOG  = 2'h3;
	// ------------------------------------------------------------
	// Update methods, timer modes, force start choices
	// ------------------------------------------------------------
	localparam logic [1:0] UPD_IMM    = 2'h0;
	localparam logic [1:0] UPD_ZERO   = 2'h1;
	localparam logic [1:0] UPD_PERIOD = 2'h2;
	localparam logic [1:0] UPD_SYNC   = 2'h3;
	localparam logic [1:0] MODE_UP     = 2'h0;
	localparam logic [1:0] MODE_DOWN   = 2'h1;
	localparam logic [1:0] MODE_UPDOWN = 2'h2;
	localparam logic [1:0] START_IMM    = 2'h0;
	localparam logic [1:0] START_ZERO   = 2'h1;
	localparam logic [1:0] START_PERIOD = 2'h2;
	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int UPD_SEL_T0   = 8;
	localparam int UPD_SEL_T1   = 10;
	localparam int FRC_GLOBAL   = 0;
	localparam int FRC_SHOT_A   = 1;
	localparam int FRC_SHOT_B   = 4;
	localparam int FRC_CONT_A   = 7;
	localparam int FRC_CONT_B   = 9;
	localparam int FRC_START    = 11;
	localparam int FRC_EN_A     = 13;
	localparam int FRC_W        = 15;
	localparam logic [CFG_W-1:0] RST_CFG = 24'h00_0000;
	localparam logic [31:0]      RD_ZERO = 32'h0000_0000;
endpackage

// file: src/pag_event_gen.sv
// Purpose: Timing events from timer count, direction and compares
// Assumes: Inputs come from logic on the same clock
// Notes:   Purely combinational; caller gates with the timer tick
module pag_event_gen
(
	input  wire logic [pag_pkg::CNT_W-1:0] i_count,
	input  wire logic [pag_pkg::CNT_W-1:0] i_period,
	input  wire logic [pag_pkg::CNT_W-1:0] i_cmp_a,
	input  wire logic [pag_pkg::CNT_W-1:0] i_cmp_b,
	input  wire logic                      i_dir_down,
	input  wire logic [1:0]                i_mode,
	input  wire logic                      i_trig_zero,
	input  wire logic                      i_trig_one,
	output logic      [pag_pkg::EV_N-1:0]  o_events
);
	wire logic zero_match   = (i_count == '0);
	wire logic period_match = (i_count == i_period);
	// Compare beyond the period can never fire
	wire logic hit_a = (i_count == i_cmp_a) && (i_cmp_a <= i_period);
	wire logic hit_b = (i_count == i_cmp_b) && (i_cmp_b <= i_period);
	wire logic updown = (i_mode == pag_pkg::MODE_UPDOWN);
	wire logic up     = !i_dir_down;

	// Up-down turns round at the ends, so only down-period and up-zero exist
	assign o_events[pag_pkg::EV_UP]  = up && period_match && !updown;
	assign o_events[pag_pkg::EV_DZ]  = !up && zero_match && !updown;
	// Up-only wraps after period, so up-period leads up-zero by a tick
	assign o_events[pag_pkg::EV_UZ]  = up && zero_match;
	// Down-only reloads after zero, so down-zero leads down-period by a tick
	assign o_events[pag_pkg::EV_DP]  = !up && period_match;
	assign o_events[pag_pkg::EV_UA]  = up && hit_a;
	assign o_events[pag_pkg::EV_UB]  = up && hit_b;
	assign o_events[pag_pkg::EV_DA]  = !up && hit_a;
	assign o_events[pag_pkg::EV_DB]  = !up && hit_b;
	assign o_events[pag_pkg::EV_UT0] = up && i_trig_zero;
	assign o_events[pag_pkg::EV_UT1] = up && i_trig_one;
	assign o_events[pag_pkg::EV_DT0] = !up && i_trig_zero;
	assign o_events[pag_pkg::EV_DT1] = !up && i_trig_one;
endmodule

// file: src/pag_action_generator.sv
// Purpose: PWM action generator for one operator, outputs A and B
// Assumes: Timer, fault and sync inputs are on i_clk_sys
// Notes:   One-shot forces act on the edge after the write, continuous ones an edge later; not truly asynchronously
//
// The address map and register access over Avalon-MM are this design's own decisions.

module pag_action_generator
(
	input  wire logic                       i_clk_sys,
	input  wire logic                       i_rst,
	input  wire logic [pag_pkg::ADDR_W-1:0] i_avs_address,
	input  wire logic                       i_avs_read,
	input  wire logic                       i_avs_write,
	input  wire logic [31:0]                i_avs_writedata,
	output logic      [31:0]                o_avs_readdata,
	output logic                            o_avs_waitrequest,
	input  wire logic [pag_pkg::CNT_W-1:0]  i_timer_count,
	input  wire logic [pag_pkg::CNT_W-1:0]  i_timer_period,
	input  wire logic                       i_timer_dir_down,
	input  wire logic [1:0]                 i_timer_mode,
	input  wire logic                       i_timer_tick,
	input  wire logic                       i_timer_running,
	input  wire logic                       i_sync_event,
	input  wire logic [2:0]                 i_fault_event,
	output logic                            o_output_a,
	output logic                            o_output_b,
	output logic      [pag_pkg::EV_N-1:0]   o_event_pulse
);
	// ------------------------------------------------------------
	// Bus slave: one wait cycle, then the answer
	// ------------------------------------------------------------
	logic [pag_pkg::CFG_W-1:0] shadow [pag_pkg::SHD_N];
	logic [pag_pkg::CFG_W-1:0] active [pag_pkg::SHD_N];
	logic [11:0]               upd_cfg;
	logic [pag_pkg::FRC_W-1:0] frc_cfg;
	logic [1:0]                level;
	logic [1:0]                shot_go;
	logic [1:0]                cont_on;
	logic                      pend_t0;
	logic                      pend_t1;

	wire logic req      = i_avs_read || i_avs_write;
	wire logic wr_take  = i_avs_write && !o_avs_waitrequest;
	wire logic rd_load  = i_avs_read && o_avs_waitrequest;
	wire logic wr_upd   = wr_take && (i_avs_address == pag_pkg::REG_UPDATE);
	wire logic wr_frc   = wr_take && (i_avs_address == pag_pkg::REG_FORCE);
	wire logic global_u = wr_frc && i_avs_writedata[pag_pkg::FRC_GLOBAL];
	wire logic [31:0] status_word = {24'h00_0000, i_timer_dir_down, i_timer_running,
		pend_t1, pend_t0, cont_on, level};
	wire logic [31:0] cmp_word = {active[1][15:0], active[0][15:0]};
	logic [31:0] rd_mux;

	always_comb
	begin
		case (i_avs_address)
			pag_pkg::REG_CMP_A, pag_pkg::REG_CMP_B,
			pag_pkg::REG_ACT_A, pag_pkg::REG_ACT_B:
				rd_mux = {8'h00, shadow[i_avs_address[1:0]]};
			pag_pkg::REG_UPDATE:  rd_mux = {20'h0_0000, upd_cfg};
			pag_pkg::REG_FORCE:   rd_mux = {17'h0_0000, frc_cfg};
			pag_pkg::REG_STATUS:  rd_mux = status_word;
			pag_pkg::REG_ACT_CMP: rd_mux = cmp_word;
			default:              rd_mux = pag_pkg::RD_ZERO;
		endcase
	end

	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_avs_waitrequest <= 1'b1;
			o_avs_readdata    <= pag_pkg::RD_ZERO;
		end
		else
		begin
			o_avs_waitrequest <= !(req && o_avs_waitrequest);
			if (rd_load)
				o_avs_readdata <= rd_mux;
		end
	end

	// ------------------------------------------------------------
	// Control registers; one-shot and global bits never store
	// ------------------------------------------------------------
	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			upd_cfg <= 12'h000;
			frc_cfg <= 15'h0000;
		end
		else
		begin
			if (wr_upd)
				upd_cfg <= i_avs_writedata[11:0];
			if (wr_frc)
				frc_cfg <= i_avs_writedata[pag_pkg::FRC_W-1:0] & 15'h7FEC;
		end
	end

	// ------------------------------------------------------------
	// Trigger sources: latched until the next timer tick
	// ------------------------------------------------------------
	// Raw fault events are used; trip gating lives elsewhere
	wire logic [3:0] trig_src = {i_sync_event, i_fault_event};
	wire logic src_t0 = trig_src[upd_cfg[pag_pkg::UPD_SEL_T0 +: 2]];
	wire logic src_t1 = trig_src[upd_cfg[pag_pkg::UPD_SEL_T1 +: 2]];
	wire logic act_en = i_timer_tick && i_timer_running;

	// Set wins over the consuming tick so a late source is kept
	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			pend_t0 <= 1'b0;
			pend_t1 <= 1'b0;
		end
		else
		begin
			pend_t0 <= (pend_t0 && !act_en) || src_t0;
			pend_t1 <= (pend_t1 && !act_en) || src_t1;
		end
	end

	// ------------------------------------------------------------
	// Events
	// ------------------------------------------------------------
	logic [pag_pkg::EV_N-1:0] ev_raw;

	pag_event_gen u_event_gen
	(
		.i_count     (i_timer_count),
		.i_period    (i_timer_period),
		.i_cmp_a     (active[0][15:0]),
		.i_cmp_b     (active[1][15:0]),
		.i_dir_down  (i_timer_dir_down),
		.i_mode      (i_timer_mode),
		.i_trig_zero (pend_t0),
		.i_trig_one  (pend_t1),
		.o_events    (ev_raw)
	);

	wire logic [pag_pkg::EV_N-1:0] ev = act_en ? ev_raw : 12'h000;

	// Reported whatever the action, so no-action events stay visible
	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
			o_event_pulse <= 12'h000;
		else
			o_event_pulse <= ev;
	end

	// ------------------------------------------------------------
	// Shadow registers: compare A, compare B, action A, action B
	// ------------------------------------------------------------
	wire logic upd_zero   = act_en && (i_timer_count == '0);
	wire logic upd_period = act_en && (i_timer_count == i_timer_period);

	genvar s;
	generate
		for (s = 0; s < pag_pkg::SHD_N; s++)
		begin : g_shadow
			wire logic [1:0] meth = upd_cfg[2*s +: 2];
			wire logic wr_s = wr_take && (i_avs_address == 4'(s));
			wire logic fire = global_u || (meth == pag_pkg::UPD_IMM) ||
				((meth == pag_pkg::UPD_ZERO) && upd_zero) ||
				((meth == pag_pkg::UPD_PERIOD) && upd_period) ||
				((meth == pag_pkg::UPD_SYNC) && i_sync_event);
			always_ff @(posedge i_clk_sys or posedge i_rst)
			begin
				if (i_rst)
				begin
					shadow[s] <= pag_pkg::RST_CFG;
					active[s] <= pag_pkg::RST_CFG;
				end
				else
				begin
					if (wr_s)
						shadow[s] <= i_avs_writedata[pag_pkg::CFG_W-1:0];
					if (fire)
						active[s] <= shadow[s];
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Priority pick: highest present event decides, even if idle
	// ------------------------------------------------------------
	function automatic logic [1:0] pag_pick(input logic [pag_pkg::EV_N-1:0] e,
		input logic [pag_pkg::CFG_W-1:0] c, input logic dn);
		logic [1:0] a;
		a = pag_pkg::ACT_NONE;
		if (!dn)
		begin
			if (e[pag_pkg::EV_UP])       a = c[2*pag_pkg::EV_UP +: 2];
			else if (e[pag_pkg::EV_UT0]) a = c[2*pag_pkg::EV_UT0 +: 2];
			else if (e[pag_pkg::EV_UT1]) a = c[2*pag_pkg::EV_UT1 +: 2];
			else if (e[pag_pkg::EV_UB])  a = c[2*pag_pkg::EV_UB +: 2];
			else if (e[pag_pkg::EV_UA])  a = c[2*pag_pkg::EV_UA +: 2];
			else if (e[pag_pkg::EV_UZ])  a = c[2*pag_pkg::EV_UZ +: 2];
		end
		else
		begin
			if (e[pag_pkg::EV_DZ])       a = c[2*pag_pkg::EV_DZ +: 2];
			else if (e[pag_pkg::EV_DT0]) a = c[2*pag_pkg::EV_DT0 +: 2];
			else if (e[pag_pkg::EV_DT1]) a = c[2*pag_pkg::EV_DT1 +: 2];
			else if (e[pag_pkg::EV_DB])  a = c[2*pag_pkg::EV_DB +: 2];
			else if (e[pag_pkg::EV_DA])  a = c[2*pag_pkg::EV_DA +: 2];
			else if (e[pag_pkg::EV_DP])  a = c[2*pag_pkg::EV_DP +: 2];
		end
		return a;
	endfunction

	// ------------------------------------------------------------
	// Output channels A and B
	// ------------------------------------------------------------
	wire logic [1:0] start_sel = frc_cfg[pag_pkg::FRC_START +: 2];
	wire logic start_hit = (start_sel == pag_pkg::START_IMM) ||
		((start_sel == pag_pkg::START_ZERO) && upd_zero) ||
		((start_sel == pag_pkg::START_PERIOD) && upd_period);
	logic [1:0] pick [2];

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++)
		begin : g_out
			// Each output has its own config, enable and force fields
			wire logic en = frc_cfg[pag_pkg::FRC_EN_A + ch];
			wire logic [1:0] shot_lvl = frc_cfg[pag_pkg::FRC_SHOT_A + 3*ch + 1 +: 2];
			wire logic [1:0] cont_lvl = frc_cfg[pag_pkg::FRC_CONT_A + 2*ch +: 2];
			// Enable rides in the same write as the shot, so take it from the bus
			wire logic shot_req = wr_frc && i_avs_writedata[pag_pkg::FRC_EN_A + ch] &&
				i_avs_writedata[pag_pkg::FRC_SHOT_A + 3*ch];
			wire logic cont_want = en && (cont_lvl != pag_pkg::ACT_NONE);
			logic next_level;

			assign pick[ch] = pag_pick(ev, active[2+ch], i_timer_dir_down);

			always_comb
			begin
				// Force outranks every timing event
				if (cont_on[ch])
					next_level = (cont_lvl == pag_pkg::ACT_HIGH);
				else if (shot_go[ch] && (shot_lvl != pag_pkg::ACT_NONE))
					next_level = (shot_lvl == pag_pkg::ACT_HIGH) ||
						((shot_lvl == pag_pkg::ACT_TOG) && !level[ch]);
				else
				begin
					case (pick[ch])
						pag_pkg::ACT_LOW:  next_level = 1'b0;
						pag_pkg::ACT_HIGH: next_level = 1'b1;
						pag_pkg::ACT_TOG:  next_level = !level[ch];
						default:           next_level = level[ch];
					endcase
				end
			end

			always_ff @(posedge i_clk_sys or posedge i_rst)
			begin
				if (i_rst)
				begin
					level[ch]   <= 1'b0;
					shot_go[ch] <= 1'b0;
					cont_on[ch] <= 1'b0;
				end
				else
				begin
					level[ch]   <= next_level;
					shot_go[ch] <= shot_req;
					cont_on[ch] <= cont_want && (cont_on[ch] || start_hit);
				end
			end
		end
	endgenerate

	// Outputs are the level flops themselves
	assign o_output_a = level[0];
	assign o_output_b = level[1];

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	wire logic [1:0] frc_any = cont_on | shot_go;
	wire logic cont_b_high = (frc_cfg[pag_pkg::FRC_CONT_B +: 2] == pag_pkg::ACT_HIGH);

	cmp_range_a:
		assert property (@(posedge i_clk_sys) disable iff (i_rst)
			(ev_raw[pag_pkg::EV_UA] || ev_raw[pag_pkg::EV_DA]) |->
			(active[0][15:0] <= i_timer_period))
		else $error("compare A event beyond period");
	updown_evt_a:
		assert property (@(posedge i_clk_sys) disable iff (i_rst)
			(i_timer_mode == pag_pkg::MODE_UPDOWN) |->
			!ev_raw[pag_pkg::EV_UP] && !ev_raw[pag_pkg::EV_DZ])
		else $error("impossible up-down event raised");
	stop_hold_a:
		assert property (@(posedge i_clk_sys) disable iff (i_rst)
			(!i_timer_running && (frc_any == 2'b00)) |=> $stable(level))
		else $error("level moved while timer stopped");
	cont_hold_a:
		assert property (@(posedge i_clk_sys) disable iff (i_rst)
			cont_on[1] |=> (level[1] == $past(cont_b_high)))
		else $error("continuous force not held on B");
	shot_lvl_a:
		assert property (@(posedge i_clk_sys) disable iff (i_rst)
			(shot_go[0] && !cont_on[0] &&
			(frc_cfg[pag_pkg::FRC_SHOT_A + 1 +: 2] == pag_pkg::ACT_LOW))
			|=> !level[0])
		else $error("one-shot low not applied on A");
	up_prio_a:
		assert property (@(posedge i_clk_sys) disable iff (i_rst)
			(ev[pag_pkg::EV_UP] && !frc_any[0] &&
			(active[2][2*pag_pkg::EV_UP +: 2] == pag_pkg::ACT_HIGH)) |=> level[0])
		else $error("up-period did not win on A");
	down_prio_a:
		assert property (@(posedge i_clk_sys) disable iff (i_rst)
			(ev[pag_pkg::EV_DZ] && !frc_any[0] &&
			(active[2][2*pag_pkg::EV_DZ +: 2] == pag_pkg::ACT_LOW)) |=> !level[0])
		else $error("down-zero did not win on A");
	toggle_b_a:
		assert property (@(posedge i_clk_sys) disable iff (i_rst)
			(!frc_any[1] && (pick[1] == pag_pkg::ACT_TOG)) |=> (level[1] != $past(level[1])))
		else $error("toggle did not invert B");
	bus_wait_a:
		assert property (@(posedge i_clk_sys) disable iff (i_rst)
			(req && o_avs_waitrequest) |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
		else $error("bus answer not after one wait cycle");

	cov_shot_c:
		cover property (@(posedge i_clk_sys) disable iff (i_rst) shot_go[0] ##1 level[0]);
	cov_cont_c:
		cover property (@(posedge i_clk_sys) disable iff (i_rst) $rose(cont_on[1]));
	cov_coinc_c:
		cover property (@(posedge i_clk_sys) disable iff (i_rst)
			ev[pag_pkg::EV_UA] && ev[pag_pkg::EV_UB]);
endmodule

// file: sim/pag_timer_model.sv
// Purpose: PWM timer model driving count, direction and tick
// Assumes: Period of four or more
// Notes:   Ticks every cycle while running; reloads while stopped
module pag_timer_model
(
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst,
	input  wire logic        i_run,
	input  wire logic [1:0]  i_mode,
	input  wire logic [15:0] i_period,
	output logic      [15:0] o_count,
	output logic             o_dir_down,
	output logic             o_tick
);
	timeunit 1ns;
	timeprecision 1ns;
	assign o_tick = i_run;
	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_count    <= 16'h0000;
			o_dir_down <= 1'b0;
		end
		else if (!i_run)
		begin
			// Reload so every run starts on a cycle boundary
			o_count    <= (i_mode == pag_pkg::MODE_DOWN) ? i_period : 16'h0000;
			o_dir_down <= (i_mode == pag_pkg::MODE_DOWN);
		end
		else if (i_mode == pag_pkg::MODE_UP)
			o_count <= (o_count >= i_period) ? 16'h0000 : o_count + 16'h0001;
		else if (i_mode == pag_pkg::MODE_DOWN)
			o_count <= (o_count == 16'h0000) ? i_period : o_count - 16'h0001;
		else if (!o_dir_down)
		begin
			o_count    <= o_count + 16'h0001;
			o_dir_down <= (o_count + 16'h0001 == i_period);
		end
		else
		begin
			o_count    <= o_count - 16'h0001;
			o_dir_down <= (o_count != 16'h0001);
		end
	end
endmodule

// file: sim/test_pag_action_generator.sv
// Purpose: Self-checking bench for the PWM action generator
// Assumes: Timer model ticks every cycle while running
// Notes:   Reference tracks levels per tick, continuous force on B included; one-shot forces checked off-line
module test_pag_action_generator;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_sys, rst, run, rd, wr, tick, dir_down;
	logic        out_a, out_b, wait_req, sync_ev, chk_on, frc_b, exp_a, exp_b, old;
	logic [1:0]  mode, lvl;
	logic [2:0]  fault_ev;
	logic [3:0]  addr;
	logic [11:0] ev_pulse, exp_ev;
	logic [15:0] period, cnt, ca, cb, p;
	logic [23:0] act_a, act_b;
	logic [31:0] wdat, rdata, rdat;
	int          num_errors, check_count;
	pag_action_generator u_pag_action_generator (.i_clk_sys(clk_sys), .i_rst(rst),
		.i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat),
		.o_avs_readdata(rdata), .o_avs_waitrequest(wait_req), .i_timer_count(cnt),
		.i_timer_period(period), .i_timer_dir_down(dir_down), .i_timer_mode(mode),
		.i_timer_tick(tick), .i_timer_running(run), .i_sync_event(sync_ev),
		.i_fault_event(fault_ev), .o_output_a(out_a), .o_output_b(out_b),
		.o_event_pulse(ev_pulse));
	pag_timer_model u_pag_timer_model (.i_clk_sys(clk_sys), .i_rst(rst), .i_run(run),
		.i_mode(mode), .i_period(period), .o_count(cnt), .o_dir_down(dir_down), .o_tick(tick));
	// ------------------------------------------------------------
	// Reference: events and levels per running tick
	// ------------------------------------------------------------
	function automatic logic [11:0] ev_of(input logic [15:0] c, input logic dn);
		logic [11:0] e;
		e = 12'h000;
		e[pag_pkg::EV_UZ] = !dn && c == 16'h0000;
		e[pag_pkg::EV_UP] = !dn && c == period && mode != pag_pkg::MODE_UPDOWN;
		e[pag_pkg::EV_UA] = !dn && c == ca && ca <= period;
		e[pag_pkg::EV_UB] = !dn && c == cb && cb <= period;
		e[pag_pkg::EV_DZ] = dn && c == 16'h0000 && mode != pag_pkg::MODE_UPDOWN;
		e[pag_pkg::EV_DP] = dn && c == period;
		e[pag_pkg::EV_DA] = dn && c == ca && ca <= period;
		e[pag_pkg::EV_DB] = dn && c == cb && cb <= period;
		return e;
	endfunction
	function automatic logic nxt(input logic [11:0] e, input logic [23:0] cfg, input logic cur);
		int         pr [12];
		logic [1:0] code;
		pr = '{pag_pkg::EV_UP, pag_pkg::EV_UT0, pag_pkg::EV_UT1, pag_pkg::EV_UB, pag_pkg::EV_UA,
			pag_pkg::EV_UZ, pag_pkg::EV_DZ, pag_pkg::EV_DT0, pag_pkg::EV_DT1, pag_pkg::EV_DB,
			pag_pkg::EV_DA, pag_pkg::EV_DP};
		for (int i = 0; i < 12; i++)
			if (e[pr[i]])
			begin
				// Highest present event decides, even when it asks for nothing
				code = cfg[2*pr[i] +: 2];
				if (code == pag_pkg::ACT_NONE)
					return cur;
				return (code == pag_pkg::ACT_TOG) ? !cur : (code == pag_pkg::ACT_HIGH);
			end
		return cur;
	endfunction
	always @(posedge clk_sys)
	begin
		exp_ev = run ? ev_of(cnt, dir_down) : 12'h000;
		if (run)
		begin
			exp_a = nxt(exp_ev, act_a, exp_a);
			exp_b = frc_b ? 1'b0 : nxt(exp_ev, act_b, exp_b);
		end
	end
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", what, e, g);
		end
	endtask
	always @(negedge clk_sys)
		if (chk_on)
		begin
			chk("events", {20'h0_0000, exp_ev}, {20'h0_0000, ev_pulse});
			chk("output a", {31'h0, exp_a}, {31'h0, out_a});
			chk("output b", {31'h0, exp_b}, {31'h0, out_b});
		end
	// ------------------------------------------------------------
	// Bus and sequencing tasks
	// ------------------------------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		addr <= a;
		wr   <= w;
		rd   <= !w;
		wdat <= d;
		// Only the watchdog ends a wait that never answers
		do
			@(posedge clk_sys);
		while (wait_req !== 1'b0);
		rdat = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask
	task automatic cfg(input logic [1:0] m, input logic [15:0] pv);
		mode   <= m;
		period <= pv;
		bus(1'b1, pag_pkg::REG_CMP_A, {16'h0000, ca});
		bus(1'b1, pag_pkg::REG_CMP_B, {16'h0000, cb});
		bus(1'b1, pag_pkg::REG_ACT_A, {8'h00, act_a});
		bus(1'b1, pag_pkg::REG_ACT_B, {8'h00, act_b});
		cyc(2);
	endtask
	task automatic run_for(input int n);
		run <= 1'b1;
		cyc(n);
		run <= 1'b0;
		cyc(3);
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial
	begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	initial
	begin
		// Whole sequence needs about a thousand cycles at most
		cyc(20000);
		num_errors++;
		close_out;
	end
	initial
	begin
		{rst, run, rd, wr, sync_ev, chk_on, frc_b, exp_a, exp_b} = 9'h100;
		{addr, wdat, fault_ev, mode, exp_ev} = '0;
		{period, ca, cb, act_a, act_b, num_errors, check_count} = '0;
		void'($urandom(32'h0366));
		cyc(2);
		chk("reset waitrequest", 32'h0000_0001, {31'h0, wait_req});
		rst <= 1'b0;
		cyc(1);
		chk("reset levels", 32'h0000_0000, {30'h0, out_a, out_b});
		bus(1'b1, pag_pkg::REG_CMP_A, 32'h0000_1234);
		bus(1'b0, pag_pkg::REG_CMP_A, 32'h0000_0000);
		chk("shadow readback", 32'h0000_1234, rdat);
		bus(1'b1, 4'h9, 32'h0000_5555);
		bus(1'b0, 4'h9, 32'h0000_0000);
		chk("unmapped read", 32'h0000_0000, rdat);
		$display("register test done");
		chk_on = 1'b1;
		for (int m = 0; m < 3; m++)
			for (int k = 0; k < 4; k++)
			begin
				p = 16'(4 + $urandom_range(12));
				ca = 16'($urandom_range(p + 2));
				cb = 16'($urandom_range(p + 2));
				act_a = 24'($urandom);
				act_b = 24'($urandom);
				if (k == 0)
				begin
					// Symmetric A with complementary B
					cb = ca + 16'h0002;
					act_a = 24'h01_0020;
					act_b = 24'h08_0040;
				end
				if (k == 1)
				begin
					// Compares coincide with period and zero
					ca = p;
					cb = 16'h0000;
				end
				cfg(2'(m), p);
				run_for(3 * p + 6);
				$display("event test mode %0d pass %0d done", m, k);
			end
		chk_on = 1'b0;
		old = exp_a;
		lvl = exp_a ? pag_pkg::ACT_LOW : pag_pkg::ACT_HIGH;
		bus(1'b1, pag_pkg::REG_FORCE, 32'h0000_2002 | {28'h000_0000, lvl, 2'b00});
		cyc(4);
		exp_a = !old;
		chk("oneshot a", {31'h0, exp_a}, {31'h0, out_a});
		chk("unforced b", {31'h0, exp_b}, {31'h0, out_b});
		chk_on = 1'b1;
		run_for(2 * p + 4);
		$display("oneshot test done");
		chk_on = 1'b0;
		act_b = 24'hFF_FFFF;
		bus(1'b1, pag_pkg::REG_ACT_B, {8'h00, act_b});
		bus(1'b1, pag_pkg::REG_FORCE, 32'h0000_4200);
		cyc(4);
		frc_b = 1'b1;
		exp_b = 1'b0;
		chk_on = 1'b1;
		run_for(2 * p + 4);
		chk_on = 1'b0;
		bus(1'b1, pag_pkg::REG_FORCE, 32'h0000_4000);
		frc_b = 1'b0;
		cyc(3);
		chk_on = 1'b1;
		run_for(2 * p + 4);
		chk_on = 1'b0;
		$display("continuous test done");
		act_a = 24'h00_0200;
		cfg(pag_pkg::MODE_UP, p);
		bus(1'b1, pag_pkg::REG_FORCE, 32'h0000_2006);
		cyc(4);
		chk("forced low", 32'h0000_0000, {31'h0, out_a});
		fault_ev <= 3'b001;
		cyc(1);
		fault_ev <= 3'b000;
		cyc(2);
		chk("stopped hold", 32'h0000_0000, {31'h0, out_a});
		run <= 1'b1;
		cyc(3);
		run <= 1'b0;
		cyc(2);
		chk("trigger high", 32'h0000_0001, {31'h0, out_a});
		$display("trigger test done");
		// Compare A waits for zero; trigger zero comes from sync
		bus(1'b1, pag_pkg::REG_UPDATE, 32'h0000_0301);
		bus(1'b1, pag_pkg::REG_CMP_A, 32'h0000_0003);
		bus(1'b0, pag_pkg::REG_ACT_CMP, 32'h0000_0000);
		chk("held compare", {cb, ca}, rdat);
		sync_ev <= 1'b1;
		cyc(1);
		sync_ev <= 1'b0;
		bus(1'b0, pag_pkg::REG_STATUS, 32'h0000_0000);
		chk("sync trigger", 32'h0000_0001, {31'h0, rdat[4]});
		bus(1'b1, pag_pkg::REG_FORCE, 32'h0000_0001);
		bus(1'b0, pag_pkg::REG_ACT_CMP, 32'h0000_0000);
		chk("global update", {cb, 16'h0003}, rdat);
		run <= 1'b1;
		cyc(2);
		run <= 1'b0;
		cyc(2);
		bus(1'b0, pag_pkg::REG_STATUS, 32'h0000_0000);
		chk("trigger consumed", 32'h0000_0000, {31'h0, rdat[4]});
		$display("update test done");
		close_out;
	end
endmodule
